/* File: dcir_top.sv */
// module: dual core interrupt routing with axi4-lite configuration
// Notes on behaviour
// - There are 147 sources and source n drives main core line n, which for n below 16 also carries ipc bit n when its dir bit is 1.
// - Each of the 32 secondary lines picks one source through a selector.
// - Priority is eight levels on the main core and four on the secondary.
// - Each core has one selectable source routed to its non-maskable input.
// - Only the 41 selected wake sources, when enabled, raise wakeup.
// - A system-function request from a core or debug port fires sec NMI.
// - 16 interprocessor structures let either core interrupt the other.
module dcir_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [dcir_pkg::NUM_SRC-1:0] irq_src,
  input wire logic main_core_syscall,
  input wire logic secondary_core_syscall,
  input wire logic debug_access_port_syscall,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [dcir_pkg::NUM_SRC-1:0] main_core_irq,
  output logic [dcir_pkg::NUM_SEC-1:0] secondary_core_irq,
  output logic main_core_nmi,
  output logic secondary_core_nmi,
  output logic main_core_req_valid,
  output logic [7:0] main_core_req_index,
  output logic secondary_core_req_valid,
  output logic [4:0] secondary_core_req_index,
  output logic wakeup
);
  import dcir_pkg::*;

  // ****************************************
  // configuration state
  // ****************************************
  logic [MAIN_PRIO_W-1:0] main_prio [NUM_SRC];
  logic [SRC_W-1:0] sec_sel [NUM_SEC];
  logic [SEC_PRIO_W-1:0] sec_prio [NUM_SEC];
  logic [SRC_W-1:0] wake_sel [NUM_WAKE];
  logic [NUM_SRC-1:0] main_en;
  logic [NUM_SEC-1:0] sec_en;
  logic [NUM_WAKE-1:0] wake_en;
  logic [SRC_W-1:0] main_nmi_sel, sec_nmi_sel;
  logic [NUM_IPC-1:0] ipc_pend, ipc_dir, next_ipc_pend;
  dcir_bus_t wstate, rstate;
  logic aw_got, w_got;
  logic [11:0] aw_q;
  logic [31:0] w_q;
  logic [3:0] ws_q;
  logic sw_syscall;

  // ****************************************
  // axi4-lite write channel
  // ****************************************
  // address and data are latched separately, so either may come first
  wire logic do_wr = aw_got && w_got && wstate == DCIR_IDLE;
  // ready is a flop, so it is driven from the state one edge ahead
  wire logic w_idle_next = !do_wr && (wstate == DCIR_IDLE || s_axi_bready);
  function automatic logic [31:0] merge(input logic [31:0] o,
    input logic [31:0] d, input logic [3:0] s);
    for (int b = 0; b < 4; b++)
      if (s[b]) o[b*8 +: 8] = d[b*8 +: 8];
    return o;
  endfunction
  function automatic logic wr_hit(input logic [11:0] a,
    input logic [11:0] b);
    return a[11:2] == b[11:2];
  endfunction
  function automatic logic mapped(input logic [11:0] a);
    return a < 12'h490 || (a >= WAKE_SEL_BASE &&
      a < WAKE_SEL_BASE + 12'(4 * NUM_WAKE));
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wstate <= DCIR_IDLE;
      {aw_got, w_got, s_axi_awready, s_axi_wready} <= 4'h0;
      {aw_q, w_q, ws_q} <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (clk_en) begin
      s_axi_awready <= w_idle_next && !aw_got &&
        !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= w_idle_next && !w_got &&
        !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        aw_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        w_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      if (do_wr) begin
        wstate <= DCIR_RESP;
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(aw_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (wstate == DCIR_RESP && s_axi_bready) begin
        wstate <= DCIR_IDLE;
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  wire logic [31:0] wv = merge(32'h0, w_q, ws_q);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NUM_SRC; i++) main_prio[i] <= '0;
      for (int i = 0; i < NUM_SEC; i++) begin
        sec_sel[i] <= SRC_W'(i);
        sec_prio[i] <= '0;
      end
      for (int i = 0; i < NUM_WAKE; i++) wake_sel[i] <= SRC_W'(i);
      main_en <= '0;
      sec_en <= '0;
      wake_en <= '0;
      main_nmi_sel <= NMI_NONE;
      sec_nmi_sel <= NMI_NONE;
      ipc_dir <= '0;
      sw_syscall <= 1'b0;
    end else if (clk_en) begin
      sw_syscall <= do_wr && wr_hit(aw_q, SYSCALL_OFF) && wv[0];
      if (do_wr) begin
        for (int i = 0; i < NUM_SRC; i++)
          if (wr_hit(aw_q, MAIN_PRIO_BASE + 12'(4 * i)))
            main_prio[i] <= wv[MAIN_PRIO_W-1:0];
        for (int i = 0; i < NUM_SEC; i++) begin
          if (wr_hit(aw_q, SEC_SEL_BASE + 12'(4 * i)))
            sec_sel[i] <= wv[SRC_W-1:0];
          if (wr_hit(aw_q, SEC_PRIO_BASE + 12'(4 * i)))
            sec_prio[i] <= wv[SEC_PRIO_W-1:0];
        end
        for (int i = 0; i < NUM_WAKE; i++)
          if (wr_hit(aw_q, WAKE_SEL_BASE + 12'(4 * i)))
            wake_sel[i] <= wv[SRC_W-1:0];
        for (int k = 0; k < 5; k++)
          if (wr_hit(aw_q, MAIN_EN_BASE + 12'(4 * k)))
            for (int b = 0; b < 32; b++)
              if (k * 32 + b < NUM_SRC) main_en[k*32+b] <= wv[b];
        if (wr_hit(aw_q, SEC_EN_OFF)) sec_en <= wv;
        for (int k = 0; k < 2; k++)
          if (wr_hit(aw_q, WAKE_EN_BASE + 12'(4 * k)))
            for (int b = 0; b < 32; b++)
              if (k * 32 + b < NUM_WAKE) wake_en[k*32+b] <= wv[b];
        if (wr_hit(aw_q, MAIN_NMI_OFF)) main_nmi_sel <= wv[SRC_W-1:0];
        if (wr_hit(aw_q, SEC_NMI_OFF)) sec_nmi_sel <= wv[SRC_W-1:0];
        if (wr_hit(aw_q, IPC_DIR_OFF)) ipc_dir <= wv[NUM_IPC-1:0];
      end
    end
  end

  // ipc: set wins over clear in the same write window
  always_comb begin
    next_ipc_pend = ipc_pend;
    if (do_wr && wr_hit(aw_q, IPC_CLR_OFF))
      next_ipc_pend = next_ipc_pend & ~wv[NUM_IPC-1:0];
    if (do_wr && wr_hit(aw_q, IPC_SET_OFF))
      next_ipc_pend = next_ipc_pend | wv[NUM_IPC-1:0];
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) ipc_pend <= '0;
    else if (clk_en) ipc_pend <= next_ipc_pend;
  end

  // ****************************************
  // routing
  // ****************************************
  // ipc bit k lands on secondary line k (dir=0) or main line k (dir=1)
  logic [NUM_SEC-1:0] sec_raw;
  logic [NUM_SRC-1:0] main_raw;
  logic [NUM_WAKE-1:0] wake_hit;
  logic [NUM_SRC*MAIN_PRIO_W-1:0] main_prio_flat;
  logic [NUM_SEC*SEC_PRIO_W-1:0] sec_prio_flat;
  always_comb begin
    for (int i = 0; i < NUM_SRC; i++) begin
      main_raw[i] = irq_src[i];
      if (i < NUM_IPC) main_raw[i] = irq_src[i] | (ipc_pend[i] & ipc_dir[i]);
      main_prio_flat[i*MAIN_PRIO_W +: MAIN_PRIO_W] = main_prio[i];
    end
    for (int i = 0; i < NUM_SEC; i++) begin
      sec_raw[i] = sec_sel[i] < SRC_W'(NUM_SRC) && irq_src[sec_sel[i]];
      if (i < NUM_IPC) sec_raw[i] = sec_raw[i] | (ipc_pend[i] & ~ipc_dir[i]);
      sec_prio_flat[i*SEC_PRIO_W +: SEC_PRIO_W] = sec_prio[i];
    end
    for (int i = 0; i < NUM_WAKE; i++)
      wake_hit[i] = wake_en[i] && wake_sel[i] < SRC_W'(NUM_SRC) &&
        irq_src[wake_sel[i]];
  end
  logic m_v, s_v;
  logic [7:0] m_idx;
  logic [4:0] s_idx;
  dcir_pick #(.N(NUM_SRC), .PW(MAIN_PRIO_W), .IW(8)) u_main_pick (
    .req(main_raw & main_en), .prio(main_prio_flat), .valid(m_v),
    .index(m_idx));
  dcir_pick #(.N(NUM_SEC), .PW(SEC_PRIO_W), .IW(5)) u_sec_pick (
    .req(sec_raw & sec_en), .prio(sec_prio_flat), .valid(s_v),
    .index(s_idx));

  // every output is a flop, one cycle behind its inputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {main_core_irq, secondary_core_irq, main_core_req_index} <= '0;
      {main_core_nmi, secondary_core_nmi, secondary_core_req_index} <= '0;
      {main_core_req_valid, secondary_core_req_valid, wakeup} <= 3'h0;
    end else if (clk_en) begin
      main_core_irq <= main_raw;
      secondary_core_irq <= sec_raw;
      main_core_nmi <= main_nmi_sel < SRC_W'(NUM_SRC) &&
        irq_src[main_nmi_sel];
      secondary_core_nmi <= (sec_nmi_sel < SRC_W'(NUM_SRC) &&
        irq_src[sec_nmi_sel]) || main_core_syscall ||
        secondary_core_syscall || debug_access_port_syscall ||
        sw_syscall;
      main_core_req_valid <= m_v;
      main_core_req_index <= m_idx;
      secondary_core_req_valid <= s_v;
      secondary_core_req_index <= s_idx;
      wakeup <= |wake_hit;
    end
  end

  // ****************************************
  // axi4-lite read channel
  // ****************************************
  logic [31:0] rd;
  wire logic [11:0] ra = s_axi_araddr;
  always_comb begin
    rd = 32'h0;
    for (int i = 0; i < NUM_SRC; i++)
      if (wr_hit(ra, MAIN_PRIO_BASE + 12'(4 * i))) rd = 32'(main_prio[i]);
    for (int i = 0; i < NUM_SEC; i++) begin
      if (wr_hit(ra, SEC_SEL_BASE + 12'(4 * i))) rd = 32'(sec_sel[i]);
      if (wr_hit(ra, SEC_PRIO_BASE + 12'(4 * i))) rd = 32'(sec_prio[i]);
    end
    for (int i = 0; i < NUM_WAKE; i++)
      if (wr_hit(ra, WAKE_SEL_BASE + 12'(4 * i))) rd = 32'(wake_sel[i]);
    for (int k = 0; k < 5; k++)
      if (wr_hit(ra, MAIN_EN_BASE + 12'(4 * k)))
        for (int b = 0; b < 32; b++)
          if (k * 32 + b < NUM_SRC) rd[b] = main_en[k*32+b];
    for (int k = 0; k < 2; k++)
      if (wr_hit(ra, WAKE_EN_BASE + 12'(4 * k)))
        for (int b = 0; b < 32; b++)
          if (k * 32 + b < NUM_WAKE) rd[b] = wake_en[k*32+b];
    if (wr_hit(ra, SEC_EN_OFF)) rd = sec_en;
    if (wr_hit(ra, MAIN_NMI_OFF)) rd = 32'(main_nmi_sel);
    if (wr_hit(ra, SEC_NMI_OFF)) rd = 32'(sec_nmi_sel);
    if (wr_hit(ra, IPC_PEND_OFF)) rd = 32'(ipc_pend);
    if (wr_hit(ra, IPC_DIR_OFF)) rd = 32'(ipc_dir);
    if (wr_hit(ra, MAIN_ACT_OFF))
      rd = {23'h0, main_core_req_valid, main_core_req_index};
    if (wr_hit(ra, SEC_ACT_OFF))
      rd = {26'h0, secondary_core_req_valid, secondary_core_req_index};
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rstate <= DCIR_IDLE;
      {s_axi_rvalid, s_axi_arready} <= 2'h0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (clk_en) begin
      s_axi_arready <= !(s_axi_arvalid && s_axi_arready) &&
        (rstate == DCIR_IDLE || s_axi_rready);
      if (s_axi_arvalid && s_axi_arready) begin
        rstate <= DCIR_RESP;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd;
        s_axi_rresp <= mapped(ra) ? RESP_OKAY : RESP_SLVERR;
      end else if (rstate == DCIR_RESP && s_axi_rready) begin
        rstate <= DCIR_IDLE;
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

/* File: dcir_pkg.sv */
// package: constants and register map of the dual core interrupt router
package dcir_pkg;
  // ****************************************
  // sizes
  // ****************************************
  localparam int NUM_SRC = 147;
  localparam int SRC_W = 8;
  localparam int NUM_SEC = 32;
  localparam int NUM_IPC = 16;
  localparam int NUM_WAKE = 41;
  localparam int MAIN_PRIO_W = 3;
  localparam int SEC_PRIO_W = 2;
  // ****************************************
  // register map (word offsets as byte addresses)
  // ****************************************
  localparam logic [11:0] MAIN_PRIO_BASE = 12'h000;
  localparam logic [11:0] SEC_SEL_BASE = 12'h300;
  localparam logic [11:0] SEC_PRIO_BASE = 12'h380;
  localparam logic [11:0] MAIN_EN_BASE = 12'h400;
  localparam logic [11:0] SEC_EN_OFF = 12'h420;
  localparam logic [11:0] WAKE_EN_BASE = 12'h440;
  localparam logic [11:0] MAIN_NMI_OFF = 12'h460;
  localparam logic [11:0] SEC_NMI_OFF = 12'h464;
  localparam logic [11:0] IPC_SET_OFF = 12'h468;
  localparam logic [11:0] IPC_CLR_OFF = 12'h46C;
  localparam logic [11:0] IPC_PEND_OFF = 12'h470;
  localparam logic [11:0] IPC_DIR_OFF = 12'h474;
  localparam logic [11:0] MAIN_ACT_OFF = 12'h478;
  localparam logic [11:0] SEC_ACT_OFF = 12'h47C;
  localparam logic [11:0] SYSCALL_OFF = 12'h480;
  localparam logic [11:0] WAKE_SEL_BASE = 12'h500;
  // ****************************************
  // reset values, response codes and bus states
  // ****************************************
  localparam logic [SRC_W-1:0] NMI_NONE = 8'hFF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    DCIR_IDLE = 2'b00,
    DCIR_RESP = 2'b01
  } dcir_bus_t;
endpackage

/* File: dcir_pick.sv */
// module: priority pick of the highest pending line
module dcir_pick #(
  parameter int N = 32,
  parameter int PW = 2,
  parameter int IW = 8
) (
  input wire logic [N-1:0] req,
  input wire logic [N*PW-1:0] prio,
  output logic valid,
  output logic [IW-1:0] index
);
  // ****************************************
  // linear scan
  // ****************************************
  // larger value is more urgent; strict > keeps the lowest index on a tie
  always_comb begin
    logic [PW-1:0] best;
    best = '0;
    valid = 1'b0;
    index = '0;
    for (int i = 0; i < N; i++) begin
      if (req[i] && (!valid || prio[i*PW +: PW] > best)) begin
        valid = 1'b1;
        best = prio[i*PW +: PW];
        index = IW'(i);
      end
    end
  end
endmodule

/* File: dcir_monitor.sv */
// checker: bus answers and routing properties of the interrupt router
module dcir_monitor
  import dcir_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [dcir_pkg::NUM_SRC-1:0] irq_src,
  input wire logic main_core_syscall,
  input wire logic secondary_core_syscall,
  input wire logic debug_access_port_syscall,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [dcir_pkg::NUM_SRC-1:0] main_core_irq,
  input wire logic main_core_nmi,
  input wire logic secondary_core_nmi,
  input wire logic main_core_req_valid,
  input wire logic [7:0] main_core_req_index,
  input wire logic wakeup
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && clk_en;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready && clk_en;
  endsequence
  chk_write_answer: assert property (s_wr_taken ##1 clk_en |=> s_axi_bvalid)
    else $error("write response missing");
  chk_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read data missing");
  chk_read_quiet: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken while read pending");
  chk_main_direct: assert property ($past(aresetn) && $past(clk_en) |->
    main_core_irq[146:16] == $past(irq_src[146:16]))
    else $error("main line differs from its source");
  chk_syscall_nmi: assert property (clk_en && (main_core_syscall ||
    secondary_core_syscall || debug_access_port_syscall)
    |=> secondary_core_nmi) else $error("syscall without nmi");
  chk_wake_quiet: assert property (clk_en && irq_src == '0 |=> !wakeup)
    else $error("wakeup without source");
  chk_nmi_quiet: assert property (clk_en && irq_src == '0 |=> !main_core_nmi)
    else $error("main nmi without source");
  chk_req_range: assert property (main_core_req_valid |->
    main_core_req_index < 8'h93) else $error("request index out of range");
endmodule
bind dcir_top dcir_monitor u_mon (.aclk, .aresetn, .clk_en, .irq_src,
  .main_core_syscall, .secondary_core_syscall, .debug_access_port_syscall,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .main_core_irq, .main_core_nmi, .secondary_core_nmi,
  .main_core_req_valid, .main_core_req_index, .wakeup);

/* File: dcir_core_model.sv */
// partner: secondary core that runs one system function per nmi edge
module dcir_core_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic nmi,
  output int nmi_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic nmi_d = 1'b0;
  int runs = 0;
  assign nmi_count = runs;
  // edge count, since a held level is one request only
  always @(posedge aclk) begin
    nmi_d <= nmi && aresetn;
    if (aresetn && nmi && !nmi_d) begin
      runs <= runs + 1;
    end
  end
endmodule

/* File: dcir_tb_top.sv */
// testbench: register bus driven scenarios for the interrupt router
module dcir_tb_top;
  import dcir_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic clk_en = 1'b1;
  logic [NUM_SRC-1:0] irq_src = '0;
  logic [2:0] sc = 3'h0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, main_core_nmi, secondary_core_nmi, wakeup;
  logic main_core_req_valid, secondary_core_req_valid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [NUM_SRC-1:0] main_core_irq;
  logic [NUM_SEC-1:0] secondary_core_irq;
  logic [7:0] main_core_req_index;
  logic [4:0] secondary_core_req_index;
  int fails = 0;
  int check_count = 0;
  int cyc = 0;
  int nmi_count, base;
  dcir_top dut (.aclk, .aresetn, .clk_en, .irq_src,
    .main_core_syscall(sc[0]), .secondary_core_syscall(sc[1]),
    .debug_access_port_syscall(sc[2]), .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .main_core_irq,
    .secondary_core_irq, .main_core_nmi, .secondary_core_nmi,
    .main_core_req_valid, .main_core_req_index, .secondary_core_req_valid,
    .secondary_core_req_index, .wakeup);
  dcir_core_model sec_core (.aclk, .aresetn, .nmi(secondary_core_nmi),
    .nmi_count);
  initial begin
    forever #12.5 aclk = ~aclk;
  end
  // ****************************************
  // tasks
  // ****************************************
  function automatic logic [NUM_SRC-1:0] one(input int n);
    return {{(NUM_SRC-1){1'b0}}, 1'b1} << n;
  endfunction
  task automatic chk(input string nm, input logic [159:0] e,
    input logic [159:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic settle();
    repeat (3) @(posedge aclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
    input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !s_axi_awready) ||
      (s_axi_wvalid && !s_axi_wready));
    do @(posedge aclk); while (!s_axi_bvalid);
    chk("bresp", 160'(er), 160'(s_axi_bresp));
    s_axi_bready <= 1'b0;
    @(posedge aclk); // idle edge, the next call may raise bready again
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e,
    input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    chk("rresp", 160'(er), 160'(s_axi_rresp));
    if (er == RESP_OKAY) chk("rdata", 160'(e), 160'(s_axi_rdata));
    s_axi_rready <= 1'b0;
    @(posedge aclk); // idle edge, the next call may raise rready again
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // cut a hang short, the whole run needs far fewer cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      summarize();
    end
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(MAIN_NMI_OFF, 32'hFF, RESP_OKAY);
    rd(SEC_SEL_BASE + 12'h014, 32'h5, RESP_OKAY);
    rd(WAKE_SEL_BASE + 12'h00C, 32'h3, RESP_OKAY);
    rd(12'h5A4, 32'h0, RESP_SLVERR);
    wr(12'h600, 32'h1, RESP_SLVERR);
    rd(IPC_SET_OFF, 32'h0, RESP_OKAY);
    irq_src <= one(0) | one(75) | one(146);
    settle();
    chk("main_irq", 160'(one(0) | one(75) | one(146)), 160'(main_core_irq));
    irq_src <= one(100);
    wr(SEC_SEL_BASE + 12'h00C, 32'h64, RESP_OKAY);
    settle();
    chk("sec_irq", 160'h8, 160'(secondary_core_irq));
    wr(SEC_SEL_BASE + 12'h00C, 32'hC8, RESP_OKAY);
    settle();
    chk("sec_irq", 160'h0, 160'(secondary_core_irq));
    wr(MAIN_PRIO_BASE, 32'hF, RESP_OKAY);
    rd(MAIN_PRIO_BASE, 32'h7, RESP_OKAY);
    wr(SEC_PRIO_BASE, 32'hF, RESP_OKAY);
    rd(SEC_PRIO_BASE, 32'h3, RESP_OKAY);
    wr(MAIN_EN_BASE, 32'h0010_0400, RESP_OKAY);
    wr(SEC_EN_OFF, 32'h6, RESP_OKAY);
    wr(MAIN_PRIO_BASE + 12'h028, 32'h2, RESP_OKAY);
    wr(MAIN_PRIO_BASE + 12'h050, 32'h5, RESP_OKAY);
    wr(SEC_PRIO_BASE + 12'h004, 32'h1, RESP_OKAY);
    wr(SEC_PRIO_BASE + 12'h008, 32'h3, RESP_OKAY);
    irq_src <= one(1) | one(2) | one(10) | one(20);
    settle();
    chk("main_idx", 160'h14, 160'(main_core_req_index));
    chk("sec_idx", 160'h2, 160'(secondary_core_req_index));
    wr(MAIN_PRIO_BASE + 12'h050, 32'h2, RESP_OKAY);
    wr(SEC_PRIO_BASE + 12'h008, 32'h1, RESP_OKAY);
    settle();
    chk("main_idx", 160'h0A, 160'(main_core_req_index));
    chk("sec_idx", 160'h1, 160'(secondary_core_req_index));
    wr(MAIN_EN_BASE, 32'h0, RESP_OKAY);
    settle();
    chk("main_valid", 160'h0, 160'(main_core_req_valid));
    chk("sec_valid", 160'h1, 160'(secondary_core_req_valid));
    rd(SEC_ACT_OFF, 32'h21, RESP_OKAY);
    irq_src <= one(146);
    wr(MAIN_NMI_OFF, 32'h92, RESP_OKAY);
    settle();
    chk("main_nmi", 160'h1, 160'(main_core_nmi));
    // enable low: outputs hold although the source falls
    clk_en <= 1'b0;
    irq_src <= '0;
    settle();
    chk("nmi_frozen", 160'h1, 160'(main_core_nmi));
    clk_en <= 1'b1;
    irq_src <= one(41);
    wr(WAKE_EN_BASE + 12'h004, 32'h100, RESP_OKAY);
    settle();
    chk("wakeup", 160'h0, 160'(wakeup));
    wr(WAKE_SEL_BASE + 12'h0A0, 32'h29, RESP_OKAY);
    settle();
    chk("wakeup", 160'h1, 160'(wakeup));
    irq_src <= '0;
    settle();
    base = nmi_count;
    for (int i = 0; i < 3; i++) begin
      sc <= 3'h1 << i;
      @(posedge aclk);
      sc <= 3'h0;
      settle();
      chk("nmi_count", 160'(base + i + 1), 160'(nmi_count));
    end
    wr(SYSCALL_OFF, 32'h1, RESP_OKAY);
    settle();
    chk("nmi_count", 160'(base + 4), 160'(nmi_count));
    wr(IPC_DIR_OFF, 32'h8, RESP_OKAY);
    // only low ipc structures used, the upper eight stay for the system
    wr(IPC_SET_OFF, 32'h18, RESP_OKAY);
    settle();
    chk("ipc_main", 160'h8, 160'(main_core_irq[15:0]));
    chk("ipc_sec", 160'h10, 160'(secondary_core_irq));
    rd(IPC_PEND_OFF, 32'h18, RESP_OKAY);
    wr(IPC_CLR_OFF, 32'h18, RESP_OKAY);
    rd(IPC_PEND_OFF, 32'h0, RESP_OKAY);
    summarize();
  end
endmodule
